// ### hw/rfpm_pkg.sv
package rfpm_pkg;

   // Bus register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TOGGLE = 8'h04;
   localparam logic [7:0] OFS_INTERVAL = 8'h08;
   localparam logic [7:0] OFS_WIDTH = 8'h0C;
   localparam logic [7:0] OFS_SYNC_DELAY = 8'h10;
   localparam logic [7:0] OFS_STEP = 8'h14;
   localparam logic [7:0] OFS_STEP_CMD = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;

   // Field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_EXT_LOW_BIT = 3;
   localparam int CTRL_GATE_LOW_BIT = 4;
   localparam int TOGGLE_BIT = 0;
   localparam int STEP_UP_BIT = 0;
   localparam int STEP_DOWN_BIT = 1;

   // Timing, all settings held in 10 ns units
   localparam int UNIT_NS = 10;
   localparam int CLK_PERIOD_NS = 40;
   localparam logic [31:0] UNITS_PER_CLK = 32'(CLK_PERIOD_NS / UNIT_NS);
   localparam int INTERVAL_MIN_NS = 100;
   localparam int INTERVAL_MAX_NS = 1000000000;
   localparam int WIDTH_MIN_NS = 50;
   localparam int WIDTH_MAX_NS = 10000000;
   localparam int SYNC_GUARD_NS = 50;
   localparam int INTERVAL_PAD_NS = 120;
   localparam int STEP_MIN_NS = 10;
   localparam int STEP_MAX_NS = 5000000;
   localparam logic [31:0] INTERVAL_MIN = 32'(INTERVAL_MIN_NS / UNIT_NS);
   localparam logic [31:0] INTERVAL_MAX = 32'(INTERVAL_MAX_NS / UNIT_NS);
   localparam logic [31:0] WIDTH_MIN = 32'(WIDTH_MIN_NS / UNIT_NS);
   localparam logic [31:0] WIDTH_MAX = 32'(WIDTH_MAX_NS / UNIT_NS);
   localparam logic [31:0] SYNC_GUARD = 32'(SYNC_GUARD_NS / UNIT_NS);
   localparam logic [31:0] INTERVAL_PAD = 32'(INTERVAL_PAD_NS / UNIT_NS);
   localparam logic [31:0] STEP_MIN = 32'(STEP_MIN_NS / UNIT_NS);
   localparam logic [31:0] STEP_MAX = 32'(STEP_MAX_NS / UNIT_NS);

   // Reset values
   localparam logic [31:0] INTERVAL_RST = 32'h0000_0064;
   localparam logic [31:0] WIDTH_RST = 32'h0000_0032;
   localparam logic [31:0] SYNC_DELAY_RST = 32'h0000_0000;
   localparam logic [31:0] STEP_RST = 32'h0000_0001;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {MODE_EXT, MODE_CONT, MODE_GATED} rfpm_mode_t;

endpackage

// ### hw/rfpm_sync.sv
`timescale 1ns/1ps
module rfpm_sync
   import rfpm_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule

// ### hw/rfpm_clamp.sv
`timescale 1ns/1ps
module rfpm_clamp
   import rfpm_pkg::*;
#(
   parameter logic [31:0] LO = 32'h0000_0000,
   parameter logic [31:0] HI = 32'hFFFF_FFFF
) (
   input wire logic [31:0] val_i,
   output logic [31:0] val_o
);
   assign val_o = (val_i < LO) ? LO : ((val_i > HI) ? HI : val_i);
endmodule

// ### hw/rfpm_top.sv
`timescale 1ns/1ps
module rfpm_top
   import rfpm_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic gate_or_level_input_i,
   input wire logic internal_gen_fitted_i,
   input wire logic cont_gated_absent_i,
   output logic rf_on_o,
   output logic video_pulse_o,
   output logic sync_marker_output_o,
   output logic pulse_mod_enable_o
);
   // Pin side: pulse input and two option straps
   logic [2:0] pins_s;
   logic level_s;
   logic fitted_s;
   logic reduced_s;

   rfpm_sync #(.W(3)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({cont_gated_absent_i, internal_gen_fitted_i, gate_or_level_input_i}),
      .q_o(pins_s)
   );
   assign level_s = pins_s[0];
   assign fitted_s = pins_s[1];
   assign reduced_s = pins_s[2];

   // Bus write side
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic wr_en;
   logic wr_hit;

   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign wr_en = aw_have_q && w_have_q && !bvalid_q;
   assign wr_hit = (aw_addr_q[7:2] <= OFS_STATUS[7:2]) && (aw_addr_q[1:0] == 2'h0);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_en) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_en) begin
            w_have_q <= 1'b0;
         end
         if (wr_en) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic wr_at(input logic en, input logic [7:0] a, input logic [7:0] ofs);
      return en && (a == ofs);
   endfunction

   // Control state
   logic enable_q;
   rfpm_mode_t mode_q;
   rfpm_mode_t mode_eff;
   logic ext_low_q;
   logic gate_low_q;
   logic [31:0] ctrl_new;
   logic [1:0] mode_req;
   logic mode_ok;
   logic internal_ok;

   // Internal modes need the generator and the full build
   assign internal_ok = fitted_s && !reduced_s;
   assign ctrl_new = merge({27'h0, gate_low_q, ext_low_q, mode_q, enable_q}, w_data_q, w_strb_q);
   assign mode_req = ctrl_new[CTRL_MODE_LSB +: 2];
   assign mode_ok = internal_ok && (mode_req == MODE_CONT || mode_req == MODE_GATED);
   // Strap can change after a mode was chosen, so gate it live too
   assign mode_eff = internal_ok ? mode_q : MODE_EXT;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= MODE_EXT;
         ext_low_q <= 1'b0;
         gate_low_q <= 1'b0;
      end else if (wr_at(wr_en, aw_addr_q, OFS_CTRL)) begin
         mode_q <= mode_ok ? rfpm_mode_t'(mode_req) : MODE_EXT;
         ext_low_q <= ctrl_new[CTRL_EXT_LOW_BIT];
         gate_low_q <= ctrl_new[CTRL_GATE_LOW_BIT];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         enable_q <= 1'b0;
      end else if (wr_at(wr_en, aw_addr_q, OFS_TOGGLE) && w_strb_q[0] && w_data_q[TOGGLE_BIT]) begin
         enable_q <= !enable_q;
      end
   end

   // Shared timing settings, one copy for every internal mode
   logic [31:0] interval_q;
   logic [31:0] width_q;
   logic [31:0] delay_q;
   logic [31:0] step_q;
   logic [31:0] width_req;
   logic [31:0] width_new;
   logic [31:0] ival_req;
   logic [31:0] ival_clamped;
   logic [31:0] ival_new;
   logic [31:0] delay_req;
   logic [31:0] delay_max;
   logic [31:0] delay_new;
   logic [31:0] step_req;
   logic [31:0] step_new;
   logic step_up;
   logic step_dn;

   assign step_up = wr_at(wr_en, aw_addr_q, OFS_STEP_CMD) && w_strb_q[0] && w_data_q[STEP_UP_BIT];
   assign step_dn = wr_at(wr_en, aw_addr_q, OFS_STEP_CMD) && w_strb_q[0]
                    && w_data_q[STEP_DOWN_BIT] && !w_data_q[STEP_UP_BIT];

   always_comb begin
      width_req = width_q;
      if (wr_at(wr_en, aw_addr_q, OFS_WIDTH)) begin
         width_req = merge(width_q, w_data_q, w_strb_q);
      end else if (step_up) begin
         width_req = width_q + step_q;
      end else if (step_dn) begin
         width_req = (width_q > step_q) ? width_q - step_q : 32'h0000_0000;
      end
   end

   rfpm_clamp #(.LO(WIDTH_MIN), .HI(WIDTH_MAX)) u_width_lim (
      .val_i(width_req),
      .val_o(width_new)
   );

   assign ival_req = wr_at(wr_en, aw_addr_q, OFS_INTERVAL) ?
                     merge(interval_q, w_data_q, w_strb_q) : interval_q;

   rfpm_clamp #(.LO(INTERVAL_MIN), .HI(INTERVAL_MAX)) u_ival_lim (
      .val_i(ival_req),
      .val_o(ival_clamped)
   );

   assign ival_new = (width_new > ival_clamped) ? width_new + INTERVAL_PAD : ival_clamped;

   // Sync delay may never reach the trailing edge region
   assign delay_max = width_new - SYNC_GUARD;
   assign delay_req = wr_at(wr_en, aw_addr_q, OFS_SYNC_DELAY) ?
                      merge(delay_q, w_data_q, w_strb_q) : delay_q;
   assign delay_new = (delay_req > delay_max) ? delay_max : delay_req;

   assign step_req = wr_at(wr_en, aw_addr_q, OFS_STEP) ? merge(step_q, w_data_q, w_strb_q) : step_q;

   rfpm_clamp #(.LO(STEP_MIN), .HI(STEP_MAX)) u_step_lim (
      .val_i(step_req),
      .val_o(step_new)
   );

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         interval_q <= INTERVAL_RST;
         width_q <= WIDTH_RST;
         delay_q <= SYNC_DELAY_RST;
         step_q <= STEP_RST;
      end else begin
         interval_q <= ival_new;
         width_q <= width_new;
         delay_q <= delay_new;
         step_q <= step_new;
      end
   end

   // Pulse generator: phase in 10 ns units, advanced once per clock
   logic [31:0] phase_q;
   logic [31:0] phase_adv;
   logic internal_mode;
   logic gen_pulse;
   logic gen_sync;

   assign internal_mode = (mode_eff == MODE_CONT) || (mode_eff == MODE_GATED);
   assign phase_adv = phase_q + UNITS_PER_CLK;

   // Wrap keeps the remainder so the average period stays exact
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_q <= 32'h0000_0000;
      end else if (!internal_mode) begin
         phase_q <= 32'h0000_0000;
      end else if (phase_adv >= interval_q) begin
         phase_q <= (phase_adv - interval_q < interval_q) ? phase_adv - interval_q : 32'h0000_0000;
      end else begin
         phase_q <= phase_adv;
      end
   end

   assign gen_pulse = phase_q < width_q;
   assign gen_sync = (phase_q >= delay_q) && (phase_q < width_q);

   // Output stage, all registered
   logic gate_active;
   logic ext_on;
   logic rf_q;
   logic video_q;
   logic sync_q;

   assign ext_on = level_s ^ ext_low_q;
   assign gate_active = level_s ^ gate_low_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rf_q <= 1'b0;
         video_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         video_q <= enable_q && internal_mode && gen_pulse;
         sync_q <= enable_q && internal_mode && gen_sync;
         unique case (mode_eff)
            MODE_EXT: rf_q <= enable_q && ext_on;
            MODE_CONT: rf_q <= enable_q && gen_pulse;
            MODE_GATED: rf_q <= enable_q && gen_pulse && gate_active;
            default: rf_q <= 1'b0;
         endcase
      end
   end

   assign rf_on_o = rf_q;
   assign video_pulse_o = video_q;
   assign sync_marker_output_o = sync_q;
   assign pulse_mod_enable_o = enable_q;

   // Bus read side
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [31:0] rd_mux;
   logic rd_hit;

   assign s_axi_arready = !rvalid_q;

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = (s_axi_araddr[1:0] == 2'h0);
      unique case (s_axi_araddr[7:2])
         OFS_CTRL[7:2]: rd_mux = {27'h0, gate_low_q, ext_low_q, mode_q, enable_q};
         OFS_TOGGLE[7:2]: rd_mux = 32'h0000_0000;
         OFS_INTERVAL[7:2]: rd_mux = interval_q;
         OFS_WIDTH[7:2]: rd_mux = width_q;
         OFS_SYNC_DELAY[7:2]: rd_mux = delay_q;
         OFS_STEP[7:2]: rd_mux = step_q;
         OFS_STEP_CMD[7:2]: rd_mux = 32'h0000_0000;
         OFS_STATUS[7:2]: rd_mux = {25'h0, internal_ok, fitted_s, level_s, sync_q, video_q,
                                    rf_q, enable_q};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_hit ? rd_mux : 32'h0000_0000;
         rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule

// ### verification/rfpm_top_checker.sv
`timescale 1ns/1ps
module rfpm_top_checker
   import rfpm_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rf_on_o,
   input wire logic video_pulse_o,
   input wire logic sync_marker_output_o,
   input wire logic pulse_mod_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence tog_take;
      wr_take ##0 (s_axi_awaddr == OFS_TOGGLE && s_axi_wdata[TOGGLE_BIT] && s_axi_wstrb[0]);
   endsequence
   enable_flip_a: assert property (tog_take |=> ##[0:2] $changed(pulse_mod_enable_o))
      else $error("enable did not flip after toggle write");
   mod_off_a: assert property (!pulse_mod_enable_o && !$past(pulse_mod_enable_o)
      |-> !rf_on_o && !video_pulse_o) else $error("output active while disabled");
   sync_end_a: assert property ($fell(video_pulse_o) |-> !sync_marker_output_o)
      else $error("sync outlives video pulse");
   busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
endmodule

bind rfpm_top rfpm_top_checker rfpm_top_checker_inst(.clk_i, .rst_i, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .rf_on_o, .video_pulse_o, .sync_marker_output_o,
   .pulse_mod_enable_o);

// ### verification/rfpm_src.sv
`timescale 1ns/1ps
module rfpm_src #(
   parameter int LAG = 1
) (
   input wire logic clk_i,
   input wire logic want_i,
   output logic pin_o
);
   // Slow source: level lands LAG edges after it is asked for
   logic [7:0] sh_q = 8'h00;
   always @(posedge clk_i) begin
      sh_q <= {sh_q[6:0], want_i};
   end
   assign pin_o = sh_q[LAG-1];
endmodule

// ### verification/rfpm_top_bench.sv
`timescale 1ns/1ps
module rfpm_top_bench
   import rfpm_pkg::*;
;
   logic clk_i = 0;
   logic rst_i = 1;
   logic awv = 0, wv = 0, bq = 0, arv = 0, rq = 0, want = 0, fit = 1, abs = 0;
   logic [7:0] aw = 0, ar = 0;
   logic [31:0] wd = 0, rd;
   logic awr, wr, bv, arr, rv, pin, rf, vid, syn, en;
   logic [1:0] bres, rres;
   int errors = 0, tests_run = 0;
   always #20 clk_i = ~clk_i;
   rfpm_top rfpm_top_inst(.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(aw),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bres), .s_axi_bvalid(bv),
      .s_axi_bready(bq), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rq),
      .gate_or_level_input_i(pin), .internal_gen_fitted_i(fit), .cont_gated_absent_i(abs),
      .rf_on_o(rf), .video_pulse_o(vid), .sync_marker_output_o(syn),
      .pulse_mod_enable_o(en));
   rfpm_src #(.LAG(3)) rfpm_src_inst(.clk_i(clk_i), .want_i(want), .pin_o(pin));
   task end_of_test;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Response ready goes up with the request and stays until the answer is sampled
   task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk_i);
      aw <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bq <= 1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk_i);
         if (awv && awr) awv <= 0;
         if (wv && wr) wv <= 0;
         if (bv) begin
            bq <= 0;
            chk(bres, er);
            return;
         end
      end
      errors++;
      $display("ERROR %0t: write answer timed out", $time);
      end_of_test;
   endtask
   task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk_i);
      ar <= a;
      arv <= 1;
      rq <= 1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk_i);
         if (arv && arr) arv <= 0;
         if (rv) begin
            rq <= 0;
            chk(rd, e);
            chk(rres, er);
            return;
         end
      end
      errors++;
      $display("ERROR %0t: read answer timed out", $time);
      end_of_test;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task cnt(output int c, output int s, output int v);
      c = 0;
      s = 0;
      v = 0;
      repeat (40) begin
         @(posedge clk_i);
         if (rf === 1'b1) c++;
         if (syn === 1'b1) s++;
         if (vid === 1'b1) v++;
      end
   endtask
   task t_reset;
      axr(OFS_CTRL, 32'h0, RESP_OKAY);
      axr(OFS_INTERVAL, 32'h64, RESP_OKAY);
      axr(OFS_WIDTH, 32'h32, RESP_OKAY);
      axr(OFS_SYNC_DELAY, 32'h0, RESP_OKAY);
      axr(OFS_STEP, 32'h1, RESP_OKAY);
      axr(8'h20, 32'h0, RESP_SLVERR);
      axw(8'h20, 32'h1, RESP_SLVERR);
      $display("reset test done");
   endtask
   task t_toggle;
      for (int i = 0; i < 3; i++) begin
         axw(OFS_TOGGLE, 32'h1, RESP_OKAY);
         cyc(1);
         chk(en, 32'(!i[0]));
      end
      $display("toggle test done");
   endtask
   task t_ext;
      for (int p = 0; p < 2; p++) begin
         axw(OFS_CTRL, 32'(p << CTRL_EXT_LOW_BIT), RESP_OKAY);
         for (int l = 0; l < 2; l++) begin
            want <= l[0];
            cyc(8);
            chk(rf, 32'(l[0] ^ p[0]));
         end
      end
      $display("external test done");
   endtask
   task t_limits;
      axw(OFS_WIDTH, 32'hFFFF_FFFF, RESP_OKAY);
      axr(OFS_WIDTH, 32'h000F_4240, RESP_OKAY);
      axr(OFS_INTERVAL, 32'h000F_424C, RESP_OKAY);
      axw(OFS_STEP, 32'hFFFF_FFFF, RESP_OKAY);
      axr(OFS_STEP, 32'h0007_A120, RESP_OKAY);
      axw(OFS_STEP, 32'h0, RESP_OKAY);
      axr(OFS_STEP, 32'h1, RESP_OKAY);
      axw(OFS_WIDTH, 32'h0, RESP_OKAY);
      axr(OFS_WIDTH, 32'h5, RESP_OKAY);
      axw(OFS_STEP, 32'h3, RESP_OKAY);
      axw(OFS_STEP_CMD, 32'h1, RESP_OKAY);
      axr(OFS_WIDTH, 32'h8, RESP_OKAY);
      axw(OFS_STEP_CMD, 32'h2, RESP_OKAY);
      axw(OFS_STEP_CMD, 32'h2, RESP_OKAY);
      axr(OFS_WIDTH, 32'h5, RESP_OKAY);
      axw(OFS_SYNC_DELAY, 32'hFFFF_FFFF, RESP_OKAY);
      axr(OFS_SYNC_DELAY, 32'h0, RESP_OKAY);
      axw(OFS_INTERVAL, 32'hFFFF_FFFF, RESP_OKAY);
      axr(OFS_INTERVAL, 32'h05F5_E100, RESP_OKAY);
      axw(OFS_INTERVAL, 32'h0, RESP_OKAY);
      axr(OFS_INTERVAL, 32'hA, RESP_OKAY);
      $display("limits test done");
   endtask
   task t_cont;
      int c, s, v;
      axw(OFS_WIDTH, 32'h14, RESP_OKAY);
      axw(OFS_INTERVAL, 32'h28, RESP_OKAY);
      axw(OFS_SYNC_DELAY, 32'h8, RESP_OKAY);
      axw(OFS_CTRL, 32'h2, RESP_OKAY);
      for (int l = 0; l < 2; l++) begin
         want <= l[0];
         cyc(8);
         cnt(c, s, v);
         chk(32'(c), 32'd20);
         chk(32'(v), 32'd20);
         chk(32'(s), 32'd12);
      end
      $display("continuous test done");
   endtask
   task t_gate;
      int c, s, v;
      for (int p = 0; p < 2; p++) begin
         axw(OFS_CTRL, 32'h4 | 32'(p << CTRL_GATE_LOW_BIT), RESP_OKAY);
         for (int l = 0; l < 2; l++) begin
            want <= l[0];
            cyc(8);
            cnt(c, s, v);
            chk(32'(c), (l[0] ^ p[0]) ? 32'd20 : 32'd0);
            chk(32'(v), 32'd20);
         end
      end
      $display("gated test done");
   endtask
   task t_strap;
      int c, s, v;
      // First pass: reduced build; second pass: no internal generator
      for (int k = 0; k < 2; k++) begin
         abs <= !k[0];
         fit <= !k[0];
         cyc(4);
         axw(OFS_CTRL, 32'h2, RESP_OKAY);
         axr(OFS_CTRL, 32'h1, RESP_OKAY);
         cnt(c, s, v);
         chk(32'(c), 32'd40);
         chk(32'(v), 32'd0);
         chk(vid, 32'h0);
      end
      $display("strap test done");
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      t_reset;
      t_toggle;
      t_ext;
      t_limits;
      t_cont;
      t_gate;
      t_strap;
      end_of_test;
   end
endmodule
